// >>> core/pct_pkg.sv
// package with offsets, fields and reset values of the compare timer
package pct_pkg;
   // ----------------------------------------
   // register map, per channel
   // ----------------------------------------
   localparam logic [4:0] CTRL_OFS = 5'h00;
   localparam logic [4:0] CMP_OFS = 5'h04;
   localparam logic [4:0] FLAG_OFS = 5'h08;
   localparam logic [4:0] SNAP_OFS = 5'h0c;
   localparam logic [4:0] IRQ_EN_OFS = 5'h10;
   localparam logic [4:0] IRQ_CLR_OFS = 5'h14;
   localparam logic [5:0] CHAN_STRIDE = 6'h20;
   // ----------------------------------------
   // control fields
   // ----------------------------------------
   localparam int RUN_BIT = 30;
   localparam int IEN_BIT = 29;
   localparam int MODE_HI = 28;
   localparam int MODE_LO = 27;
   localparam int CLR_BIT = 26;
   localparam int ACT_BIT = 25;
   localparam int SNAP_BIT = 16;
   localparam int DIV_HI = 7;
   localparam logic [7:0] DIV_RESET = 8'h05;
   localparam logic [23:0] CMP_RESET = 24'h000000;
   localparam logic [1:0] MODE_ONESHOT = 2'h0;
   localparam logic [1:0] MODE_PERIODIC = 2'h1;
   localparam logic [1:0] MODE_CONT = 2'h3;
endpackage : pct_pkg

// >>> core/pct_channel.sv
// one timer channel: prescaler, 24-bit up-counter, compare and flag
`timescale 1ns/100ps
module pct_channel (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic run_set,
   input wire logic run_wval,
   input wire logic clear_pulse,
   input wire logic cmp_write,
   input wire logic [23:0] cmp_wdata,
   input wire logic flag_clear,
   input wire logic [1:0] mode,
   input wire logic [7:0] divisor,
   input wire logic snap_en,
   output logic run,
   output logic [23:0] compare_value,
   output logic [23:0] count_value,
   output logic match_flag,
   output logic irq_set
);
   logic run_reg, run_next;
   logic [7:0] psc_reg, psc_next;
   logic [23:0] cnt_reg, cnt_next;
   logic [23:0] cmp_reg, cmp_next;
   logic [23:0] snap_reg, snap_next;
   logic flag_reg, flag_next;
   logic tick;
   logic hit;

   // ----------------------------------------
   // counting
   // ----------------------------------------
   // prescaler wraps at divisor, so divide is divisor+1
   always_comb begin
      tick = run_reg && (psc_reg >= divisor);
      hit = tick && (cnt_reg + 24'h000001 == cmp_reg);
      run_next = run_reg;
      psc_next = psc_reg;
      cnt_next = cnt_reg;
      cmp_next = cmp_reg;
      snap_next = snap_reg;
      flag_next = flag_reg;
      if (run_set) begin
         run_next = run_wval;
      end
      if (run_reg) begin
         psc_next = tick ? 8'h00 : psc_reg + 8'h01;
         if (tick) begin
            cnt_next = cnt_reg + 24'h000001;
         end
      end
      if (hit) begin
         if (mode != pct_pkg::MODE_CONT) begin
            cnt_next = 24'h000000;
         end
         if (mode == pct_pkg::MODE_ONESHOT) begin
            run_next = 1'b0;
         end
      end
      // clear first, then hardware set wins over software clear
      if (flag_clear) begin
         flag_next = 1'b0;
      end
      if (hit) begin
         flag_next = 1'b1;
      end
      if (snap_en && run_reg) begin
         snap_next = cnt_next;
      end
      if (cmp_write) begin
         cmp_next = cmp_wdata;
         cnt_next = 24'h000000;
         psc_next = 8'h00;
      end
      if (clear_pulse) begin
         psc_next = 8'h00;
         cnt_next = 24'h000000;
         run_next = 1'b0;
      end
   end

   // state registers, frozen while ce is low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         run_reg <= 1'b0;
         psc_reg <= 8'h00;
         cnt_reg <= 24'h000000;
         cmp_reg <= pct_pkg::CMP_RESET;
         snap_reg <= 24'h000000;
         flag_reg <= 1'b0;
      end else if (ce) begin
         run_reg <= run_next;
         psc_reg <= psc_next;
         cnt_reg <= cnt_next;
         cmp_reg <= cmp_next;
         snap_reg <= snap_next;
         flag_reg <= flag_next;
      end
   end

   assign run = run_reg;
   assign compare_value = cmp_reg;
   assign count_value = snap_reg;
   assign match_flag = flag_reg;
   assign irq_set = hit && ce;
endmodule : pct_channel

// >>> core/pct_timer.sv
// two independent compare timers behind an avalon-mm slave
// How it works
// - run bit advances counter, resumes held value
// - one-shot match flags once, clears run
// - periodic mode matches every period; 2 reserved
// - continuous mode matches without clearing counter
// - irq enable gates interrupt request output
// - counter-clear write resets prescaler, counter, run
// - read-only active bit shows counter running
// - snapshot register follows counter when enabled and running
// - prescaler divides clock by divisor plus one
// - control resets to 0x0000_0005
// - match sets flag; write one clears
// - compare write restarts count from zero
// - period is clock times divisor+1 times compare
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/100ps
module pct_timer #(
   parameter int CHANNELS = 2
) (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic [5:0] ADDRESS,
   input wire logic READ,
   input wire logic WRITE,
   input wire logic [31:0] WRITEDATA,
   input wire logic [3:0] BYTEENABLE,
   output logic [31:0] READDATA,
   output logic WAITREQUEST,
   output logic [CHANNELS-1:0] TIMER_IRQ,
   output logic IRQ
);
   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic ack_reg, ack_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [CHANNELS-1:0] ien_reg, ien_next;
   logic [CHANNELS-1:0] sts_reg, sts_next;
   logic [1:0] mode_reg [CHANNELS], mode_next [CHANNELS];
   logic [7:0] div_reg [CHANNELS], div_next [CHANNELS];
   logic [CHANNELS-1:0] snap_en_reg, snap_en_next;
   logic [CHANNELS-1:0] run, flag, hit, ctl_wr, cmp_wr, flag_wr;
   logic [23:0] cmpv [CHANNELS];
   logic [23:0] cntv [CHANNELS];
   logic [4:0] ofs;
   logic [0:0] sel;
   logic req;
   logic full_word;
   logic wr_go;

   // single wait cycle, answer on the second edge of a request
   assign req = (READ || WRITE) && !ack_reg;
   assign WAITREQUEST = (READ || WRITE) && !ack_reg;
   assign ofs = ADDRESS[4:0];
   assign sel = ADDRESS[5:5];
   assign full_word = &BYTEENABLE; // partial writes ignored except at IRQ_CLR_OFS, fields span lanes
   // a write lands only on the edge where waitrequest is seen low, never twice
   assign wr_go = WRITE && ack_reg;

   // per-channel strobes
   always_comb begin
      ctl_wr = '0;
      cmp_wr = '0;
      flag_wr = '0;
      for (int i = 0; i < CHANNELS; i++) begin
         if (wr_go && full_word && sel == i[0:0]) begin
            ctl_wr[i] = (ofs == pct_pkg::CTRL_OFS);
            cmp_wr[i] = (ofs == pct_pkg::CMP_OFS);
            flag_wr[i] = (ofs == pct_pkg::FLAG_OFS) && WRITEDATA[0];
         end
      end
   end

   // ----------------------------------------
   // channels
   // ----------------------------------------
   for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
      pct_channel u_chan (
         .clk(MCLK),
         .rst(RST),
         .ce(CE),
         .run_set(ctl_wr[g]),
         .run_wval(WRITEDATA[pct_pkg::RUN_BIT]),
         .clear_pulse(ctl_wr[g] && WRITEDATA[pct_pkg::CLR_BIT]),
         .cmp_write(cmp_wr[g]),
         .cmp_wdata(WRITEDATA[23:0]),
         .flag_clear(flag_wr[g]),
         .mode(mode_reg[g]),
         .divisor(div_reg[g]),
         .snap_en(snap_en_reg[g]),
         .run(run[g]),
         .compare_value(cmpv[g]),
         .count_value(cntv[g]),
         .match_flag(flag[g]),
         .irq_set(hit[g])
      );
   end

   // ----------------------------------------
   // control, interrupt and read mux
   // ----------------------------------------
   always_comb begin
      ack_next = req;
      rdata_next = rdata_reg;
      ien_next = ien_reg;
      sts_next = sts_reg;
      snap_en_next = snap_en_reg;
      for (int i = 0; i < CHANNELS; i++) begin
         mode_next[i] = mode_reg[i];
         div_next[i] = div_reg[i];
         if (ctl_wr[i]) begin
            ien_next[i] = WRITEDATA[pct_pkg::IEN_BIT];
            mode_next[i] = WRITEDATA[pct_pkg::MODE_HI:pct_pkg::MODE_LO];
            snap_en_next[i] = WRITEDATA[pct_pkg::SNAP_BIT];
            div_next[i] = WRITEDATA[pct_pkg::DIV_HI:0];
         end
         if (wr_go && sel == i[0:0] && ofs == pct_pkg::IRQ_CLR_OFS) begin
            sts_next[i] = sts_next[i] & ~WRITEDATA[0];
         end
         if (hit[i]) begin
            sts_next[i] = 1'b1; // set beats clear
         end
      end
      if (READ && req) begin
         rdata_next = 32'h00000000; // unmapped reads return zero
         case (ofs)
            pct_pkg::CTRL_OFS: begin
               rdata_next[pct_pkg::RUN_BIT] = run[sel];
               rdata_next[pct_pkg::IEN_BIT] = ien_reg[sel];
               rdata_next[pct_pkg::MODE_HI:pct_pkg::MODE_LO] = mode_reg[sel];
               rdata_next[pct_pkg::ACT_BIT] = run[sel];
               rdata_next[pct_pkg::SNAP_BIT] = snap_en_reg[sel];
               rdata_next[pct_pkg::DIV_HI:0] = div_reg[sel];
            end
            pct_pkg::CMP_OFS: rdata_next[23:0] = cmpv[sel];
            pct_pkg::FLAG_OFS: rdata_next[0] = flag[sel];
            pct_pkg::SNAP_OFS: rdata_next[23:0] = cntv[sel];
            pct_pkg::IRQ_EN_OFS: rdata_next[0] = ien_reg[sel];
            pct_pkg::IRQ_CLR_OFS: rdata_next[0] = sts_reg[sel];
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   // registers, frozen while CE is low
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         ien_reg <= '0;
         sts_reg <= '0;
         snap_en_reg <= '0;
         for (int i = 0; i < CHANNELS; i++) begin
            mode_reg[i] <= pct_pkg::MODE_ONESHOT;
            div_reg[i] <= pct_pkg::DIV_RESET;
         end
      end else if (CE) begin
         ack_reg <= ack_next;
         rdata_reg <= rdata_next;
         ien_reg <= ien_next;
         sts_reg <= sts_next;
         snap_en_reg <= snap_en_next;
         for (int i = 0; i < CHANNELS; i++) begin
            mode_reg[i] <= mode_next[i];
            div_reg[i] <= div_next[i];
         end
      end
   end

   assign READDATA = rdata_reg;
   assign TIMER_IRQ = sts_reg & ien_reg;
   assign IRQ = |(sts_reg & ien_reg);
endmodule : pct_timer

// >>> testbench/pct_timer_assertions.sv
// port assertions for the two-channel compare timer
`timescale 1ns/100ps
module pct_timer_chk #(
   parameter int CHANNELS = 2
) (
   input wire logic MCLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic [5:0] ADDRESS,
   input wire logic READ,
   input wire logic WRITE,
   input wire logic [31:0] WRITEDATA,
   input wire logic [3:0] BYTEENABLE,
   input wire logic [31:0] READDATA,
   input wire logic WAITREQUEST,
   input wire logic [CHANNELS-1:0] TIMER_IRQ,
   input wire logic IRQ
);
   // ----------------------------------------
   // bus and interrupt relations
   // ----------------------------------------
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   chk_wait_raised: assert property ($rose(READ || WRITE) |-> WAITREQUEST)
      else $error("request not held off");
   chk_wait_once: assert property (WAITREQUEST && CE |=> !WAITREQUEST)
      else $error("more than one wait cycle");
   chk_irq_or: assert property (IRQ == (|TIMER_IRQ))
      else $error("irq is not the or of channels");
   chk_unmapped_zero: assert property (READ && !WAITREQUEST && ADDRESS[4:0] > 5'h14
      |-> READDATA == 32'h0) else $error("unmapped read not zero");
   chk_ctrl_reserved: assert property (READ && !WAITREQUEST && ADDRESS[4:0] == 5'h00
      |-> (READDATA & 32'h81fe_ff00) == 32'h0) else $error("control reserved set");
   chk_flag_reserved: assert property (READ && !WAITREQUEST && ADDRESS[4:0] == 5'h08
      |-> READDATA[31:1] == 31'h0) else $error("flag reserved set");
   chk_snap_upper: assert property (READ && !WAITREQUEST && ADDRESS[4:0] == 5'h0c
      |-> READDATA[31:24] == 8'h0) else $error("snapshot upper set");
   // channel 0's interrupt only drops after software wrote something
   chk_irq_fall: assert property ($fell(TIMER_IRQ[0]) |-> $past(WRITE))
      else $error("irq dropped without a write");
   chk_read_hold: assert property (!(READ && WAITREQUEST) |=> $stable(READDATA))
      else $error("read data moved without a read");
   cover property ($rose(TIMER_IRQ[1]));
   cover property ($fell(IRQ));
   cover property (WRITE && !WAITREQUEST);
endmodule : pct_timer_chk

// >>> testbench/testbench.sv
// self-checking bench for the two-channel compare timer
`timescale 1ns/100ps
module testbench;
   logic MCLK = 0, RST = 1, CE = 1, READ = 0, WRITE = 0, WAITREQUEST, IRQ;
   logic [5:0] ADDRESS = 6'h00;
   logic [31:0] WRITEDATA = 32'h0, READDATA, rdv, s1, c;
   logic [3:0] BYTEENABLE = 4'hf;
   logic [1:0] TIMER_IRQ;
   logic [63:0] expq[$], e;
   logic [31:0] seed = 32'h826c;
   int errors = 0, checks = 0, cyc = 0, rise = 0, tw = 0, t0 = 0, ts = 0;
   pct_timer DUT (.MCLK(MCLK), .RST(RST), .CE(CE), .ADDRESS(ADDRESS), .READ(READ),
      .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
      .WAITREQUEST(WAITREQUEST), .TIMER_IRQ(TIMER_IRQ), .IRQ(IRQ));
   always #10 MCLK = ~MCLK;
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   // one avalon cycle; a read notes its expectation, masked, for the monitor
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
      input logic [31:0] m = 32'hffff_ffff);
      int n = 0;
      @(posedge MCLK);
      ADDRESS <= a;
      WRITEDATA <= d;
      READ <= !w;
      WRITE <= w;
      if (!w) expq.push_back({m, d});
      do begin
         @(posedge MCLK);
         n++;
      end while (WAITREQUEST !== 1'b0 && n < 50);
      if (n >= 50) begin
         errors++;
         give_verdict();
      end
      tw = cyc;
      rdv = READDATA;
      READ <= 1'b0;
      WRITE <= 1'b0;
   endtask : bus
   // bounded wait for a channel interrupt, noting the cycle it was seen
   task automatic waitirq(input int ch);
      int n = 0;
      do begin
         @(posedge MCLK);
         n++;
      end while (TIMER_IRQ[ch] !== 1'b1 && n < 900);
      if (n >= 900) begin
         errors++;
         give_verdict();
      end
      rise = cyc;
   endtask : waitirq
   // the request line follows the status bit, so both flags must be dropped
   task automatic ack_irq(input logic [5:0] b);
      bus(1, b | 6'h08, 32'h1);
      bus(1, b | 6'h14, 32'h1);
   endtask : ack_irq
   // monitor: takes the oldest note at each completed read
   always @(posedge MCLK) begin
      cyc <= cyc + 1;
      if (READ === 1'b1 && WAITREQUEST === 1'b0 && expq.size() > 0) begin
         e = expq.pop_front();
         cmp(READDATA & e[63:32], e[31:0] & e[63:32]);
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge MCLK);
      RST <= 1'b0;
      bus(0, 6'h00, 32'h5);
      bus(0, 6'h20, 32'h5);
      // a write with lanes missing must leave the compare value alone
      BYTEENABLE <= 4'h3;
      bus(1, 6'h04, 32'h7);
      BYTEENABLE <= 4'hf;
      bus(0, 6'h04, 32'h0);
      bus(1, 6'h18, rnd());
      bus(0, 6'h18, 32'h0);
      $display("test reset done");
      // one-shot, divide by two: run drops, flag set until cleared, no further interrupt
      bus(1, 6'h04, 32'h0a);
      bus(1, 6'h00, 32'h6000_0001);
      waitirq(0);
      bus(0, 6'h00, 32'h2000_0001);
      cmp({31'h0, IRQ}, 32'h1);
      bus(0, 6'h08, 32'h1);
      ack_irq(6'h00);
      bus(0, 6'h08, 32'h0);
      repeat (60) @(posedge MCLK);
      cmp({30'h0, TIMER_IRQ}, 32'h0);
      $display("test oneshot done");
      // periodic: exact period, then a pause that delays the next match
      bus(1, 6'h00, 32'h6800_0001);
      waitirq(0);
      t0 = rise;
      ack_irq(6'h00);
      waitirq(0);
      cmp(rise - t0, 32'h14);
      t0 = rise;
      ack_irq(6'h00);
      bus(1, 6'h00, 32'h2800_0001);
      ts = tw;
      repeat (7) @(posedge MCLK);
      bus(1, 6'h00, 32'h6800_0001);
      waitirq(0);
      cmp(rise - t0, 32'h14 + tw - ts);
      $display("test periodic done");
      // clear bit, then continuous count with snapshot on and off
      bus(1, 6'h00, 32'h4400_0000);
      bus(0, 6'h00, 32'h0);
      ack_irq(6'h00);
      bus(1, 6'h04, 32'h30);
      bus(1, 6'h00, 32'h7801_0000);
      waitirq(0);
      bus(0, 6'h0c, 32'h0, 32'hff00_0000);
      s1 = rdv;
      bus(0, 6'h0c, 32'h0, 32'hff00_0000);
      cmp(rdv - s1, 32'h3);
      cmp({31'h0, s1 > 32'h30}, 32'h1);
      bus(1, 6'h00, 32'h7800_0000);
      bus(0, 6'h0c, 32'h0, 32'hff00_0000);
      s1 = rdv;
      bus(0, 6'h0c, 32'h0, 32'hff00_0000);
      cmp(rdv, s1);
      ack_irq(6'h00);
      $display("test continuous done");
      // second channel with a random compare, first one still counting in continuous mode
      c = 32'h14 + (rnd() & 32'hf);
      bus(1, 6'h24, c);
      bus(1, 6'h20, 32'h6800_0000);
      waitirq(1);
      t0 = rise;
      ack_irq(6'h20);
      waitirq(1);
      cmp(rise - t0, c);
      cmp({31'h0, TIMER_IRQ[0]}, 32'h0);
      $display("test channel done");
      give_verdict();
   end
endmodule : testbench
bind pct_timer pct_timer_chk #(.CHANNELS(CHANNELS)) chk (.MCLK(MCLK), .RST(RST), .CE(CE),
   .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA),
   .BYTEENABLE(BYTEENABLE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
   .TIMER_IRQ(TIMER_IRQ), .IRQ(IRQ));
